// [design/cidt_core.sv]
// decode and cycle timing of 14-bit instruction words
`timescale 1ns/1ns
// Notes on behaviour
// - every instruction is one 14-bit word holding opcode and all operands.
// - opcodes are classed as byte-oriented, bit-oriented or literal-and-control.
// - an instruction not listed as an exception completes in one instruction cycle.
// - both subroutine entries, direct and via accumulator, take two cycles.
// - subroutine return, return with literal and interrupt exit take two cycles.
// - absolute, relative and accumulator jumps take two; bit-test and inc/dec skips take two only when the skip is taken.
// - an indirect access whose pointer points at program memory adds one cycle.
// - one instruction cycle spans four oscillator clocks.
// - a write that names a file register is a read-modify-write of that register.
// - destination bit clear sends the result to the accumulator, set to the register.
// - the file address operand spans 0x00 to 0x7F within a bank.
// - the bit operand selects one of eight bits of a file register.
// - don't-care positions of the word never change execution.
// - the pointer selector operand picks pointer pair zero or one.
// - the two-bit mode picks pre/post increment/decrement of the pointer.
// - the literal operand carries an immediate constant or a program target.
module cidt_core
    import cidt_pkg::*;
(
    input wire logic clk_sys, // oscillator clock
    input wire logic arst_n, // async reset, active low
    input wire logic [13:0] insn_word, // word from program memory
    input wire logic insn_valid, // word present on insn_word
    input wire logic [15:0] ptr0, // indirect_pointer 0
    input wire logic [15:0] ptr1, // indirect_pointer 1
    input wire logic skip_taken, // skip condition met in execute
    output logic insn_fetch, // take the word this clock
    output logic cycle_end, // last clock of an instruction cycle
    output logic exec_strobe, // operation executes this clock
    output logic [1:0] group, // decoded opcode group
    output logic [6:0] f_addr, // file register address
    output logic [2:0] bit_sel, // bit position
    output logic [7:0] bit_mask, // one-hot bit mask
    output logic dest_file, // result to file register
    output logic rmw_read, // read phase of read-modify-write
    output logic rmw_write, // write-back phase
    output logic acc_write, // result to accumulator
    output logic [10:0] lit_k, // literal or target field
    output logic ptr_sel, // pointer pair selection
    output logic [1:0] ptr_mode, // pre/post inc/dec mode
    output logic ptr_update, // adjust selected pointer now
    output logic [1:0] insn_cycles, // cycles decoded at fetch, without the extra cycle of a taken skip
    output logic nop_cycle, // inserted no-operation cycle
    output logic flush // discard prefetched word
);
    // ----------------------------------------------------------------
    // clock phase divider
    // ----------------------------------------------------------------
    logic [1:0] phase_q;
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            phase_q <= 2'h0;
        end else begin
            phase_q <= phase_q + 2'h1;
        end
    end
    logic phase_end;
    assign phase_end = (phase_q == PHASE_LAST);

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_EXTRA} cidt_state_t;
    cidt_state_t state_q;
    logic [13:0] ir_q;
    logic [1:0] left_q;
    logic [1:0] total_q;
    logic [1:0] need_d;

    // decode of the word being fetched
    logic [13:0] w;
    logic is_entry;
    logic is_entry_acc;
    logic is_abs_jump;
    logic is_rel_jump;
    logic is_acc_jump;
    logic is_sub_exit;
    logic is_lit_exit;
    logic is_int_exit;
    logic is_bit_skip;
    logic is_file_skip;
    logic is_ind_move;
    logic is_byte_form;
    logic is_byte_group;
    logic is_bit_form;
    logic names_port;
    logic uses_port;
    logic port_sel;
    logic ind_prog;
    logic is_skip_q;
    logic skip_now;
    logic [7:0] mask_d;
    logic [10:0] lit_d;
    assign w = insn_word;

    // ----------------------------------------------------------------
    // opcode classes
    // ----------------------------------------------------------------
    assign is_entry = (w[13:11] == 3'b100);
    assign is_entry_acc = (w == OP_ENTRY_ACC);
    assign is_abs_jump = (w[13:11] == 3'b101);
    assign is_rel_jump = (w[13:9] == 5'b11001);
    assign is_acc_jump = (w == OP_JUMP_ACC);
    assign is_sub_exit = (w == OP_RETURN);
    assign is_lit_exit = (w[13:8] == 6'b110100);
    assign is_int_exit = (w == OP_INT_EXIT);
    // bit-test skips, skip if bit clear and skip if bit set
    assign is_bit_skip = (w[13:11] == 3'b011);
    assign is_file_skip = (w[13:8] == 6'b001011) || (w[13:8] == 6'b001111);
    assign is_ind_move = (w[13:4] == OP_INDMOV);

    // byte and bit forms carry a file address in the low seven bits
    assign is_bit_form = (w[13:12] == 2'b01);
    assign is_byte_form = (w[13:12] == 2'b00) && (w[13:7] != 7'h00);
    // control forms with a zero upper byte stay out of the byte group
    assign is_byte_group = (w[13:12] == 2'b00) && (w[13:8] != 6'h00);

    // indirect access ports sit at file addresses 0 and 1
    assign names_port = (w[6:0] == FADDR_INDIRECT0) || (w[6:0] == FADDR_INDIRECT1);
    assign uses_port = is_ind_move || ((is_byte_form || is_bit_form) && names_port);
    assign port_sel = is_ind_move ? w[N_POS] : w[F_LSB];
    assign ind_prog = port_sel ? ptr1[PTR_PROG_BIT] : ptr0[PTR_PROG_BIT];

    // ----------------------------------------------------------------
    // cycles needed
    // ----------------------------------------------------------------
    always_comb begin
        need_d = 2'h1;
        if (is_entry || is_entry_acc) begin
            need_d = 2'h2;
        end
        if (is_sub_exit || is_lit_exit || is_int_exit) begin
            need_d = 2'h2;
        end
        if (is_abs_jump || is_rel_jump || is_acc_jump) begin
            need_d = 2'h2;
        end
        // skips take their second cycle only when the skip is taken
        if (uses_port && ind_prog) begin
            need_d = need_d + 2'h1;
        end
    end

    // a taken skip squashes the next word, so no fetch may close that cycle
    assign skip_now = (state_q == ST_EXEC) && is_skip_q && skip_taken;
    assign insn_fetch = phase_end && insn_valid && !skip_now
        && (state_q == ST_IDLE || left_q == 2'h1);

    // ----------------------------------------------------------------
    // sequencer state
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= ST_IDLE;
            left_q <= 2'h0;
        end else if (phase_end) begin
            if (insn_fetch) begin
                state_q <= ST_EXEC;
                left_q <= need_d;
            end else if (skip_now) begin
                // one inserted cycle on top of what is still owed
                state_q <= ST_EXTRA;
                left_q <= left_q;
            end else if (left_q > 2'h1) begin
                state_q <= ST_EXTRA;
                left_q <= left_q - 2'h1;
            end else begin
                state_q <= ST_IDLE;
                left_q <= 2'h0;
            end
        end
    end

    // cycle count reported for the instruction in flight
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            total_q <= 2'h0;
        end else if (insn_fetch) begin
            total_q <= need_d;
        end
    end

    // ----------------------------------------------------------------
    // word capture
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ir_q <= 14'h0000;
        end else if (insn_fetch) begin
            ir_q <= insn_word;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            is_skip_q <= 1'b0;
        end else if (insn_fetch) begin
            is_skip_q <= is_bit_skip || is_file_skip;
        end
    end

    // ----------------------------------------------------------------
    // timing outputs
    // ----------------------------------------------------------------
    logic exec_now;
    assign exec_now = (state_q == ST_EXEC) && (left_q == total_q);
    assign nop_cycle = (state_q == ST_EXTRA);
    assign cycle_end = phase_end;
    assign insn_cycles = total_q;
    // flush lands on the first clock of each inserted cycle
    assign flush = nop_cycle && phase_q == 2'h0;

    // ----------------------------------------------------------------
    // operand fields of the held word
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            group <= CIDT_GRP_BYTE;
        end else if (insn_fetch) begin
            if (is_bit_form) begin
                group <= CIDT_GRP_BIT;
            end else if (is_byte_group) begin
                group <= CIDT_GRP_BYTE;
            end else begin
                group <= CIDT_GRP_LITCTL;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            f_addr <= 7'h00;
        end else if (insn_fetch) begin
            f_addr <= w[6:0] & FADDR_MAX;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            bit_sel <= 3'h0;
        end else if (insn_fetch) begin
            bit_sel <= w[9:7];
        end
    end

    // one decoder per bit of the file register
    for (genvar gi = 0; gi < DATA_W; gi++) begin : g_mask
        assign mask_d[gi] = (w[9:7] == 3'(gi));
    end
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            bit_mask <= 8'h00;
        end else if (insn_fetch) begin
            bit_mask <= mask_d;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            dest_file <= 1'b0;
        end else if (insn_fetch) begin
            dest_file <= w[D_POS];
        end
    end

    // short literals leave the upper bits clear whatever the word holds there
    always_comb begin
        lit_d = {3'b000, w[7:0]};
        if (is_entry || is_abs_jump) begin
            lit_d = w[10:0];
        end else if (is_rel_jump) begin
            lit_d = {2'b00, w[8:0]};
        end
    end
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            lit_k <= 11'h000;
        end else if (insn_fetch) begin
            lit_k <= lit_d;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ptr_sel <= 1'b0;
        end else if (insn_fetch) begin
            ptr_sel <= port_sel;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ptr_mode <= 2'h0;
        end else if (insn_fetch) begin
            ptr_mode <= w[1:0];
        end
    end

    // ----------------------------------------------------------------
    // execution strobes, only in the first cycle
    // ----------------------------------------------------------------
    logic byte_wr;
    assign byte_wr = (group == CIDT_GRP_BYTE) || (group == CIDT_GRP_BIT && ir_q[11] == 1'b0);
    assign exec_strobe = exec_now && phase_end;
    assign rmw_read = exec_now && byte_wr && phase_q == 2'h1;
    assign rmw_write = exec_now && byte_wr && phase_end && (dest_file || group == CIDT_GRP_BIT);
    assign acc_write = exec_now && phase_end && group == CIDT_GRP_BYTE && !dest_file;
    assign ptr_update = exec_now && phase_end && ir_q[13:4] == OP_INDMOV;
endmodule // cidt_core

// [design/cidt_pkg.sv]
// constants and types for the instruction decode and cycle timing block
package cidt_pkg;
    localparam int INSN_W = 14;
    localparam int DATA_W = 8;
    localparam int FADDR_W = 7;
    localparam int BIT_W = 3;
    localparam int PC_W = 15;
    localparam int CLK_PER_CYCLE = 4;
    localparam logic [1:0] PHASE_LAST = 2'(CLK_PER_CYCLE - 1);
    // bit 15 of the indirect pointer marks program memory
    localparam int PTR_W = 16;
    localparam int PTR_PROG_BIT = 15;
    // file address of the indirect access ports (0 and 1)
    localparam logic [6:0] FADDR_INDIRECT0 = 7'h00;
    localparam logic [6:0] FADDR_INDIRECT1 = 7'h01;
    localparam logic [6:0] FADDR_MAX = 7'h7F;
    // field positions
    localparam int F_LSB = 0;
    localparam int D_POS = 7;
    localparam int B_LSB = 7;
    localparam int N_POS = 2;
    localparam int MM_LSB = 0;
    // opcode patterns
    localparam logic [13:0] OP_RETURN = 14'h0008;
    localparam logic [13:0] OP_INT_EXIT = 14'h0009;
    localparam logic [13:0] OP_ENTRY_ACC = 14'h000A;
    localparam logic [13:0] OP_JUMP_ACC = 14'h000B;
    localparam logic [3:0] OP_MOVIW_HI = 4'h0;   // 000000_0001_0nmm, bits 13:4 == 0x001
    localparam logic [9:0] OP_INDMOV = 10'h001;

    typedef enum logic [1:0] {
        CIDT_GRP_BYTE, CIDT_GRP_BIT, CIDT_GRP_LITCTL
    } cidt_group_t;

    typedef enum logic [1:0] {
        CIDT_MM_PREINC, CIDT_MM_PREDEC, CIDT_MM_POSTINC, CIDT_MM_POSTDEC
    } cidt_mm_t;
endpackage

// [bench/cidt_core_sva.sv]
// assertions on the ports of the decode and timing core
`timescale 1ns/1ns
module cidt_core_sva (
    input wire logic clk_sys, // clock
    input wire logic arst_n, // async reset
    input wire logic insn_fetch, // word taken
    input wire logic cycle_end, // last clock of a cycle
    input wire logic exec_strobe, // execute clock
    input wire logic [1:0] group, // opcode group
    input wire logic [2:0] bit_sel, // bit operand
    input wire logic [7:0] bit_mask, // one-hot mask
    input wire logic dest_file, // result to file
    input wire logic rmw_read, // rmw read phase
    input wire logic rmw_write, // rmw write phase
    input wire logic acc_write, // result to accumulator
    input wire logic nop_cycle, // inserted cycle
    input wire logic flush // prefetch discard
);
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);
    chk_cycle_four: assert property (cycle_end |=> !cycle_end [*3] ##1 cycle_end)
        else $error("cycle length wrong");
    chk_exec_delay: assert property (insn_fetch |-> ##4 exec_strobe)
        else $error("execute not one cycle after fetch");
    chk_fetch_gap: assert property (insn_fetch |=> !insn_fetch [*3])
        else $error("fetches too close");
    chk_rmw_order: assert property (rmw_read |-> ##2 (rmw_write || acc_write))
        else $error("read without write-back");
    chk_dest_steer: assert property (acc_write |-> !dest_file && !rmw_write)
        else $error("result steered wrongly");
    chk_mask_onehot: assert property (exec_strobe && group == 2'h1 |->
        bit_mask == 8'h01 << bit_sel) else $error("bit mask wrong");
    chk_nop_quiet: assert property (nop_cycle |-> !(exec_strobe || rmw_write || acc_write))
        else $error("work in inserted cycle");
    chk_flush_first: assert property ($rose(nop_cycle) |-> flush)
        else $error("no flush at inserted cycle");
endmodule // cidt_core_sva

bind cidt_core cidt_core_sva chk_u (.*);

// [bench/cidt_pmem.sv]
// program memory model offering one whole word at a time
`timescale 1ns/1ns
module cidt_pmem (
    input wire logic clk_sys, // clock
    input wire logic arst_n, // async reset
    input wire logic load, // bench offers a word
    input wire logic [13:0] load_word, // offered word
    input wire logic insn_fetch, // core takes the word
    output logic [13:0] insn_word, // word to the core
    output logic insn_valid // word on offer
);
    logic valid_q;
    logic [13:0] word_q;
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            valid_q <= 1'b0;
            word_q <= 14'h0000;
        end else if (load) begin
            valid_q <= 1'b1;
            word_q <= load_word;
        end else if (insn_fetch) begin
            valid_q <= 1'b0;
        end
    end
    // nothing on offer: inverse so a stale sample never matches
    assign insn_word = valid_q ? word_q : ~word_q;
    assign insn_valid = valid_q;
endmodule // cidt_pmem

// [bench/cidt_core_test.sv]
// self-checking bench for the decode and timing core
`timescale 1ns/1ns
module cidt_core_test;
    import cidt_pkg::*;
    typedef struct {logic [13:0] w; logic [15:0] p; logic sk; logic cf; logic [1:0] g, c;} cidt_row_t;
    logic clk_sys = 1'b0, arst_n = 1'b0, load = 1'b0, skip_taken = 1'b0;
    logic [13:0] load_word = 14'h0000, insn_word;
    logic [15:0] ptr = 16'h0000;
    logic insn_valid, insn_fetch, cycle_end, exec_strobe, dest_file, rmw_read, rmw_write;
    logic acc_write, ptr_sel, ptr_update, nop_cycle, flush;
    logic [1:0] group, ptr_mode, insn_cycles;
    logic [6:0] f_addr;
    logic [2:0] bit_sel;
    logic [7:0] bit_mask;
    logic [10:0] lit_k;
    int err_total = 0, num_checks = 0;
    // word, pointer, skip, check fields, group, cycles
    cidt_row_t rows[20] = '{'{14'h07FF, 0, 0, 1, 0, 1}, '{14'h0700, 0, 0, 1, 0, 1},
        '{14'h0700, 16'h8000, 0, 1, 0, 2}, '{14'h0781, 16'h8000, 0, 1, 0, 2},
        '{14'h0702, 16'h8000, 0, 1, 0, 1}, '{14'h15A5, 0, 0, 1, 1, 1}, '{14'h2FFF, 0, 0, 1, 2, 2},
        '{14'h2123, 0, 0, 1, 2, 2}, '{14'h000A, 0, 0, 0, 2, 2}, '{14'h0008, 0, 0, 0, 2, 2},
        '{14'h0009, 0, 0, 0, 2, 2}, '{14'h3455, 0, 0, 0, 2, 2}, '{14'h321F, 0, 0, 0, 2, 2},
        '{14'h000B, 0, 0, 0, 2, 2}, '{14'h1C25, 0, 1, 0, 1, 2}, '{14'h1C25, 0, 0, 0, 1, 1},
        '{14'h1825, 0, 1, 0, 1, 2}, '{14'h0B25, 0, 1, 0, 0, 2}, '{14'h0F25, 0, 1, 0, 0, 2},
        '{14'h0060, 0, 0, 0, 0, 1}};
    cidt_pmem pm_u (.*);
    cidt_core dut_u (.ptr0(ptr), .ptr1(ptr), .*);
    always #25 clk_sys = ~clk_sys;
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // offer a word, wait for the take, then count inserted cycles
    task automatic run(input logic [13:0] w, input logic [15:0] p, input logic sk,
        output logic [1:0] c);
        int n, k;
        n = 0;
        k = 0;
        @(posedge clk_sys);
        load <= 1'b1;
        load_word <= w;
        ptr <= p;
        skip_taken <= sk;
        @(posedge clk_sys);
        load <= 1'b0;
        do @(negedge clk_sys); while (insn_fetch !== 1'b1 && ++n < 40);
        repeat (16) begin
            @(negedge clk_sys);
            k += (nop_cycle === 1'b1);
        end
        c = 2'(1 + k / 4);
    endtask
    initial begin
        logic [1:0] c;
        logic [10:0] fld;
        repeat (12) @(posedge clk_sys);
        arst_n <= 1'b1;
        foreach (rows[i]) begin
            run(rows[i].w, rows[i].p, rows[i].sk, c);
            chk(c, rows[i].c);
            fld = rows[i].g == 2'h2 ? lit_k : rows[i].g == 2'h1 ? {bit_sel, f_addr} : {dest_file, f_addr};
            if (rows[i].cf) chk({group, fld}, {rows[i].g, rows[i].g == 2'h2 ? rows[i].w[10:0] :
                rows[i].g == 2'h1 ? rows[i].w[9:0] : rows[i].w[7:0]});
        end
        for (int i = 0; i < 8; i++) begin
            run(14'h0010 | 14'(i), 16'h0000, 1'b0, c);
            chk({ptr_sel, ptr_mode}, 16'(i));
        end
        // reset lands while a two-cycle jump is in flight
        @(posedge clk_sys);
        load <= 1'b1;
        load_word <= 14'h2FFF;
        repeat (9) @(posedge clk_sys);
        arst_n <= 1'b0;
        load <= 1'b0;
        @(negedge clk_sys);
        chk({group, insn_cycles, nop_cycle}, 16'h0000);
        @(posedge clk_sys);
        arst_n <= 1'b1;
        run(14'h07FF, 16'h0000, 1'b0, c);
        chk(c, 2'h1);
        stop_test();
    end
    initial begin
        // about 30 words at under 60 clocks each
        repeat (4000) @(posedge clk_sys);
        err_total++;
        stop_test();
    end
endmodule // cidt_core_test
